// [verilog/lin_mode_ctrl.sv]
// Mode control and data path of a single-wire bus transceiver.
// Assumes a serial front end that delivers mode writes and select level.
`timescale 1ns/1ps
`default_nettype none
`include "lin_xcvr_consts.svh"

// Operation
// R01: Start in off mode after power-up; off selectable in every device mode.
// R02: Off mode request accepted whatever the chip operating mode.
// R03: Off mode ignores bus wake activity and reports no wake.
// R04: Software writes mode bits; device applies the written mode.
// R05: Normal mode may be entered by command only in chip Normal mode.
// R06: Normal mode keeps working in chip Normal and Stop modes.
// R07: Normal mode drives bus from transmit input, low dominant.
// R08: Receive output continuously shows the received bus level.
// R09: Receive-only mode disables driver, keeps reception; Normal and Stop only.
// R10: Wake on falling edge, long dominant, rising edge; then hold receive low.
// R11: After wake mode reads 01; rearm by other mode or Stop/Sleep/Fail-Safe.
// R12: Stuck dominant transmit input blocks driver, sets failure flag until released; code holds the flag until lin_fail_clr.
// R13: Off mode keeps receive output high and driver disabled.
// R14: Mode write applies when select returns high; disallowed requests ignored.
module lin_mode_ctrl
  import lin_xcvr_pkg::*;
#(
  parameter int WAKE_CYC = `LIN_WAKE_FILT_US * `LIN_CLK_MHZ,
  parameter int TXD_CYC  = `LIN_TXD_TO_US * `LIN_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic      clock,
  input  wire logic      sys_rst,
  input  wire logic      clk_en,
  // Chip operating mode
  input  wire dev_mode_e dev_mode,
  // Serial control
  input  wire logic      mode_wr_strobe,
  input  wire logic [1:0] mode_wr_data,
  input  wire logic      serial_select_n,
  output logic     [1:0] mode_bits_out,
  // Microcontroller data
  input  wire logic      lin_tx_data_in,
  output logic           lin_rx_data_out,
  // Bus pin
  input  wire logic      lin_bus_in,
  output logic           lin_bus_out,
  output logic           lin_bus_oe_n,
  // Status
  output logic           wake_event,
  output logic           lin_fail_flag,
  input  wire logic      lin_fail_clr
);

  // =========================================
  // Elaboration check
  if (WAKE_CYC < 1 || TXD_CYC < 1) begin : g_bad
    $error("lin_mode_ctrl timing counts must be at least one");
  end

  lin_state_e state_reg, state_next;
  mode_code_t pend_code_reg;
  logic       pend_valid_reg;
  logic       sel_prev_reg;
  logic       bus_prev_reg;
  dev_mode_e  dev_prev_reg;
  logic       rx_reg, oe_n_reg, wake_reg, fail_reg;

  timer_if wake_tmr ();
  timer_if txd_tmr ();

  // =========================================
  // Timers for wake filter and transmit time-out
  dom_timer #(.COUNT(WAKE_CYC)) u_wake_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .tmr     (wake_tmr.timer)
  );

  dom_timer #(.COUNT(TXD_CYC)) u_txd_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .tmr     (txd_tmr.timer)
  );

  assign wake_tmr.run = (state_reg == ST_WK_DOM) && !lin_bus_in; // R10
  assign txd_tmr.run  = (state_reg == ST_NORMAL) && !lin_tx_data_in; // R12

  // =========================================
  // Request decode
  wire        cs_rise   = !sel_prev_reg && serial_select_n;
  wire        req_live  = mode_wr_strobe || pend_valid_reg;
  wire [1:0]  req_code  = mode_wr_strobe ? mode_wr_data : pend_code_reg;
  wire        apply     = cs_rise && req_live; // R14
  wire        dev_nrm   = (dev_mode == DEV_NORMAL);
  wire        dev_stp   = (dev_mode == DEV_STOP);
  wire        dev_run   = dev_nrm || dev_stp; // R06
  wire        dev_chg   = (dev_mode != dev_prev_reg);
  wire        enter_fs  = dev_chg && (dev_mode == DEV_FAIL_SAFE);
  wire        enter_rearm = dev_chg && (dev_stp || dev_mode == DEV_SLEEP
                                        || dev_mode == DEV_FAIL_SAFE); // R11
  wire        in_wake   = (state_reg == ST_WK_IDLE) || (state_reg == ST_WK_DOM)
                          || (state_reg == ST_WOKEN);
  wire        req_off   = (req_code == `LIN_MODE_OFF);
  wire        req_wake  = (req_code == `LIN_MODE_WAKE);
  wire        req_rx    = (req_code == `LIN_MODE_RXONLY);
  wire        req_nrm   = (req_code == `LIN_MODE_NORMAL);
  wire        req_ok    = req_off                                  // R02
                          || (req_wake && dev_mode != DEV_FAIL_SAFE)
                          || (req_rx && dev_run)                   // R09
                          || (req_nrm && dev_nrm);                 // R05
  wire        req_take  = apply && req_ok && !(req_wake && in_wake); // R14
  wire        tx_block  = txd_tmr.expired; // R12

  // =========================================
  // Next transceiver state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WK_IDLE: begin
        if (bus_prev_reg && !lin_bus_in) state_next = ST_WK_DOM; // R10
      end
      ST_WK_DOM: begin
        if (lin_bus_in) state_next = wake_tmr.expired ? ST_WOKEN : ST_WK_IDLE; // R10
      end
      ST_NORMAL, ST_RXONLY: begin
        if (!dev_run) state_next = ST_WK_IDLE; // R06
      end
      ST_OFF, ST_WOKEN: begin
        state_next = state_reg; // R03
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (req_take) begin // R04
      if (req_off) state_next = ST_OFF;
      else if (req_wake) state_next = ST_WK_IDLE;
      else if (req_rx) state_next = ST_RXONLY;
      else state_next = ST_NORMAL;
    end
    if (enter_fs) state_next = ST_WK_IDLE;
    else if (enter_rearm && state_reg == ST_WOKEN) state_next = ST_WK_IDLE; // R11
  end

  // =========================================
  // Mode bits readback
  assign mode_bits_out = (state_reg == ST_NORMAL) ? `LIN_MODE_NORMAL :
                         (state_reg == ST_RXONLY) ? `LIN_MODE_RXONLY :
                         in_wake                  ? `LIN_MODE_WAKE   :
                                                    `LIN_MODE_OFF; // R11

  // =========================================
  // Pin side next values
  wire rx_next   = (state_reg == ST_OFF)   ? 1'b1 :     // R13
                   (state_reg == ST_WOKEN) ? 1'b0 :     // R10
                                             lin_bus_in; // R08
  wire oe_n_next = !((state_reg == ST_NORMAL) && !lin_tx_data_in && !tx_block); // R07
  wire wake_next = (state_next == ST_WOKEN) && (state_reg != ST_WOKEN);
  wire fail_next = (tx_block && (state_reg == ST_NORMAL)) // R12
                   || (fail_reg && !lin_fail_clr);

  // =========================================
  // State and request registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg      <= ST_OFF; // R01
      pend_valid_reg <= 1'b0;
      pend_code_reg  <= `LIN_MODE_OFF;
      sel_prev_reg   <= `LIN_SEL_RST;
      bus_prev_reg   <= `LIN_BUS_RST;
      dev_prev_reg   <= DEV_NORMAL;
    end else if (clk_en) begin
      state_reg      <= state_next;
      pend_valid_reg <= req_live && !cs_rise; // R14
      pend_code_reg  <= req_code;
      sel_prev_reg   <= serial_select_n;
      bus_prev_reg   <= lin_bus_in;
      dev_prev_reg   <= dev_mode;
    end
  end

  // =========================================
  // Output registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_reg   <= 1'b1;
      oe_n_reg <= 1'b1;
      wake_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (clk_en) begin
      rx_reg   <= rx_next;
      oe_n_reg <= oe_n_next;
      wake_reg <= wake_next;
      fail_reg <= fail_next;
    end
  end

  assign lin_rx_data_out = rx_reg;
  assign lin_bus_oe_n    = oe_n_reg;
  assign lin_bus_out     = 1'b0; // Dominant level only
  assign wake_event      = wake_reg;
  assign lin_fail_flag   = fail_reg;

  // =========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_reset_off;
    $past(sys_rst) |-> state_reg == ST_OFF;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("not off after reset"); // R01

  property p_off_nowake;
    (state_reg == ST_OFF) && clk_en |=> !wake_event;
  endproperty
  a_off_nowake: assert property (p_off_nowake) else $error("wake in off mode"); // R03

  property p_normal_gate;
    (state_reg != ST_NORMAL) && apply && req_nrm && !dev_nrm && clk_en
      |=> state_reg != ST_NORMAL;
  endproperty
  a_normal_gate: assert property (p_normal_gate) else $error("normal outside Normal"); // R05

  property p_tx_drive;
    (state_reg == ST_NORMAL) && !tx_block && clk_en
      |=> lin_bus_oe_n == $past(lin_tx_data_in);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("bus not following tx"); // R07

  property p_rx_follow;
    (state_reg == ST_NORMAL || state_reg == ST_RXONLY) && clk_en
      |=> lin_rx_data_out == $past(lin_bus_in);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx not following bus"); // R08

  property p_rxonly;
    (state_reg == ST_RXONLY) && clk_en |=> lin_bus_oe_n;
  endproperty
  a_rxonly: assert property (p_rxonly) else $error("driver on in rx-only"); // R09

  property p_woken_rx;
    (state_reg == ST_WOKEN) && clk_en
      |-> (mode_bits_out == `LIN_MODE_WAKE) ##1 !lin_rx_data_out;
  endproperty
  a_woken_rx: assert property (p_woken_rx) else $error("woken rx or bits wrong"); // R10

  sequence s_long_dom;
    (state_reg == ST_WK_DOM) && wake_tmr.expired && lin_bus_in && clk_en
      && !req_take && !enter_fs;
  endsequence
  property p_wake_detect;
    s_long_dom |=> (state_reg == ST_WOKEN) && wake_event;
  endproperty
  a_wake_detect: assert property (p_wake_detect) else $error("wake not detected"); // R10

  sequence s_stuck;
    (state_reg == ST_NORMAL) && !lin_tx_data_in && tx_block && clk_en;
  endsequence
  property p_txd_block;
    s_stuck |=> lin_bus_oe_n && lin_fail_flag;
  endproperty
  a_txd_block: assert property (p_txd_block) else $error("time-out not applied"); // R12

  property p_off_quiet;
    (state_reg == ST_OFF) && clk_en |=> lin_rx_data_out && lin_bus_oe_n;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("off mode not quiet"); // R13

endmodule // lin_mode_ctrl

`default_nettype wire

// [verilog/lin_xcvr_consts.svh]
// Constants for the single-wire bus transceiver mode control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LIN_XCVR_CONSTS_SVH
`define LIN_XCVR_CONSTS_SVH

// Transceiver mode codes as written and read back
`define LIN_MODE_OFF    2'h0
`define LIN_MODE_WAKE   2'h1
`define LIN_MODE_RXONLY 2'h2
`define LIN_MODE_NORMAL 2'h3

// Clock rate and timing
`define LIN_CLK_MHZ     125
`define LIN_WAKE_FILT_US 30
`define LIN_TXD_TO_US   20000

// Reset values
`define LIN_SEL_RST     1'b1
`define LIN_BUS_RST     1'b1

`endif

// [verilog/lin_xcvr_pkg.sv]
// Types for the transceiver mode control.
// Assumes the constants header sits beside it.
`include "lin_xcvr_consts.svh"

package lin_xcvr_pkg;

  // Overall operating mode of the chip
  typedef enum logic [2:0] {
    DEV_NORMAL    = 3'h0,
    DEV_STOP      = 3'h1,
    DEV_SLEEP     = 3'h2,
    DEV_RESTART   = 3'h3,
    DEV_FAIL_SAFE = 3'h4
  } dev_mode_e;

  // Transceiver states, one-hot
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_NORMAL  = 6'h02,
    ST_RXONLY  = 6'h04,
    ST_WK_IDLE = 6'h08,
    ST_WK_DOM  = 6'h10,
    ST_WOKEN   = 6'h20
  } lin_state_e;

  typedef logic [1:0] mode_code_t;

endpackage

// [verilog/timer_if.sv]
// Handshake between the mode control and a dominant-time timer.
// Assumes both ends share the same clock.
`timescale 1ns/1ps
`default_nettype none

interface timer_if;
  logic run;
  logic expired;
  modport timer (input run, output expired);
  modport user  (output run, input expired);
endinterface

`default_nettype wire

// [verilog/dom_timer.sv]
// Saturating counter that flags a level held for COUNT enabled cycles.
// Assumes a synchronous active-high reset and a common clock enable.
`timescale 1ns/1ps
`default_nettype none

module dom_timer #(
  parameter int COUNT = 4
) (
  // Clock and control
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Timer handshake
  timer_if.timer   tmr
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(COUNT);

  // =========================================
  // Elaboration check
  if (COUNT < 1) begin : g_bad
    $error("dom_timer COUNT must be at least one");
  end

  logic [CW-1:0] count_reg;

  // =========================================
  // Count while run is high, clear otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (clk_en) begin
      if (!tmr.run) count_reg <= '0;
      else if (count_reg != LIMIT) count_reg <= count_reg + CW'(1);
    end
  end

  assign tmr.expired = (count_reg == LIMIT);

endmodule // dom_timer

`default_nettype wire

// [verif/lin_bus_node.sv]
// Far-side model: bus wire with pull-up, remote node and device driver.
// Assumes the bench drives the remote node's dominant request.
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Bus node model
module lin_bus_node (
  // Device driver
  input  wire logic lin_bus_out,
  input  wire logic lin_bus_oe_n,
  // Remote node
  input  wire logic remote_dom,
  // Wire level
  output logic      bus_level
);
  // Wired-and with pull-up, recessive when nobody pulls
  assign bus_level = (lin_bus_oe_n | lin_bus_out) & ~remote_dom;
endmodule // lin_bus_node

`default_nettype wire

// [verif/lin_transceiver_mode_control_test.sv]
// Self-checking bench for the transceiver mode control.
// Assumes the design files and the bus node model are compiled first.
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Bench top
module lin_transceiver_mode_control_test
  import lin_xcvr_pkg::*;
();
  logic       clock, sys_rst, clk_en, strobe, sel_n, tx, remote, fail_clr;
  logic       rx, bus_out, oe_n, wake, fail, bus, ptx, pbus;
  logic [1:0] wr_data, mode_bits;
  dev_mode_e  dev;
  mode_code_t exp_mode;
  int         num_errors, checked;

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Design and far side
  lin_mode_ctrl #(.WAKE_CYC(4), .TXD_CYC(8)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .dev_mode(dev),
    .mode_wr_strobe(strobe), .mode_wr_data(wr_data), .serial_select_n(sel_n),
    .mode_bits_out(mode_bits), .lin_tx_data_in(tx), .lin_rx_data_out(rx),
    .lin_bus_in(bus), .lin_bus_out(bus_out), .lin_bus_oe_n(oe_n),
    .wake_event(wake), .lin_fail_flag(fail), .lin_fail_clr(fail_clr));
  lin_bus_node i_bus (.lin_bus_out(bus_out), .lin_bus_oe_n(oe_n),
    .remote_dom(remote), .bus_level(bus));

  // ========================================
  // Expectation functions
  function automatic mode_code_t req_next(mode_code_t cur, mode_code_t req, dev_mode_e d);
    case (req)
      2'h0: return req;
      2'h1: return (d == DEV_FAIL_SAFE) ? cur : req;
      2'h2: return (d == DEV_NORMAL || d == DEV_STOP) ? req : cur;
      default: return (d == DEV_NORMAL) ? req : cur;
    endcase
  endfunction

  function automatic mode_code_t dev_next(mode_code_t cur, dev_mode_e o, dev_mode_e n);
    if (n != o && n == DEV_FAIL_SAFE) return 2'h1;
    if (n != o && (n == DEV_SLEEP || n == DEV_RESTART) && cur[1]) return 2'h1;
    return cur;
  endfunction

  // ========================================
  // Bench tasks
  task automatic check(logic [1:0] seen, logic [1:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Wait edges, then step just past the last one
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Mode write: strobe with select low, applied on select rise
  task automatic write_mode(mode_code_t code);
    sel_n = 1'b0;
    strobe = 1'b1;
    wr_data = code;
    cyc(1);
    strobe = 1'b0;
    check(mode_bits, exp_mode);
    sel_n = 1'b1;
    exp_mode = req_next(exp_mode, code, dev);
    cyc(2);
    check(mode_bits, exp_mode);
  endtask

  task automatic set_dev(dev_mode_e d);
    exp_mode = dev_next(exp_mode, dev, d);
    dev = d;
    cyc(2);
    check(mode_bits, exp_mode);
  endtask

  // Random transmit and remote traffic; rxk below zero means rx follows bus
  task automatic run_data(int n, bit drv, int rxk);
    for (int i = 0; i < n; i++) begin
      tx = (i % 4 == 3) || $urandom_range(1);
      remote = ($urandom_range(3) == 0);
      #6;
      ptx = tx;
      pbus = bus;
      cyc(1);
      check(oe_n, drv ? ptx : 1'b1);
      check(rx, (rxk < 0) ? pbus : rxk[0]);
    end
    remote = 1'b0;
    tx = 1'b1;
  endtask

  // Remote dominant pulse of len cycles, watching for a wake pulse
  task automatic wake_pulse(int len, bit exp_ev);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < len + 6; i++) begin
      remote = (i >= 1) && (i <= len);
      cyc(1);
      seen |= wake;
    end
    check(seen, exp_ev);
  endtask

  // ========================================
  // Main sequence
  initial begin
    clk_en = 1'b1;
    sys_rst = 1'b1;
    strobe = 1'b0;
    sel_n = 1'b1;
    wr_data = 2'h0;
    tx = 1'b1;
    remote = 1'b0;
    fail_clr = 1'b0;
    dev = DEV_NORMAL;
    exp_mode = 2'h0;
    num_errors = 0;
    checked = 0;
    void'($urandom(26));
    cyc(4);
    sys_rst = 1'b0;
    check(mode_bits, 2'h0);
    check(oe_n, 1'b1);
    check(bus_out, 1'b0);
    run_data(12, 0, 1);
    wake_pulse(8, 0);
    // Every request in every chip mode
    for (int d = 0; d < 5; d++) begin
      for (int c = 0; c < 4; c++) begin
        set_dev(dev_mode_e'(d));
        write_mode(mode_code_t'(c));
      end
    end
    // Random chip modes and requests
    for (int i = 0; i < 20; i++) begin
      set_dev(dev_mode_e'($urandom_range(4)));
      write_mode(mode_code_t'($urandom_range(3)));
    end
    // Data path in normal and receive-only
    set_dev(DEV_NORMAL);
    write_mode(2'h3);
    run_data(24, 1, -1);
    // Clock enable low freezes the driver
    cyc(1);
    clk_en = 1'b0;
    tx = 1'b0;
    cyc(3);
    check(oe_n, 1'b1);
    clk_en = 1'b1;
    cyc(1);
    check(oe_n, 1'b0);
    tx = 1'b1;
    set_dev(DEV_STOP);
    run_data(12, 1, -1);
    write_mode(2'h2);
    run_data(16, 0, -1);
    // Stuck dominant transmit input
    set_dev(DEV_NORMAL);
    write_mode(2'h3);
    tx = 1'b0;
    cyc(12);
    check(oe_n, 1'b1);
    check(fail, 1'b1);
    tx = 1'b1;
    cyc(2);
    tx = 1'b0;
    cyc(2);
    check(oe_n, 1'b0);
    tx = 1'b1;
    fail_clr = 1'b1;
    cyc(1);
    fail_clr = 1'b0;
    cyc(1);
    check(fail, 1'b0);
    // Wake detection, hold and rearm
    write_mode(2'h1);
    wake_pulse(2, 0);
    wake_pulse(8, 1);
    run_data(6, 0, 0);
    check(mode_bits, 2'h1);
    write_mode(2'h1);
    wake_pulse(8, 0);
    write_mode(2'h0);
    write_mode(2'h1);
    wake_pulse(8, 1);
    set_dev(DEV_STOP);
    wake_pulse(8, 1);
    // Second reset in mid-run, then two requests
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    exp_mode = 2'h0;
    check(mode_bits, exp_mode);
    check(rx, 1'b1);
    write_mode(2'h3);
    write_mode(2'h2);
    finish_test();
  end
endmodule // lin_transceiver_mode_control_test

`default_nettype wire
